/* File: include/drsu_map.svh */
`ifndef DRSU_MAP_SVH
`define DRSU_MAP_SVH

`define DRSU_OP_DREAD      8'h3b
`define DRSU_OP_DIOREAD    8'hbb
`define DRSU_OP_RDSR       8'h05
`define DRSU_OP_WRSR       8'h01
`define DRSU_OP_WREN       8'h06
`define DRSU_OP_WRDI       8'h04

`define DRSU_SR_BUSY       0
`define DRSU_SR_WEN        1
`define DRSU_SR_LOCK       7
`define DRSU_SR_NV_MASK    8'hbc

`define DRSU_D_CMD_END     6'h07
`define DRSU_D_DR_ADDR_END 6'h1f
`define DRSU_D_DR_DUM_END  6'h27
`define DRSU_D_DIO_ADR_END 6'h13
`define DRSU_D_DIO_DUM_END 6'h17
`define DRSU_D_WRSR_END    6'h0f
`define DRSU_D_CNT_MAX     6'h3f
`define DRSU_D_PAIR_LAST   2'h3

`define DRSU_H_CMD_LAST    12'h007
`define DRSU_H_DR_ADDR_END 12'h01f
`define DRSU_H_DR_DUM_END  12'h027
`define DRSU_H_DIO_ADR_END 12'h013
`define DRSU_H_DIO_DRV_END 12'h015
`define DRSU_H_DIO_IDX     12'h027
`define DRSU_H_WRSR_END    12'h00f
`define DRSU_H_DR_DSTART   12'h028
`define DRSU_H_DIO_DSTART  12'h018
`define DRSU_H_SR_DSTART   12'h008
`define DRSU_H_WRSR_TOTAL  12'h010
`define DRSU_H_ONE_TOTAL   12'h008

`endif

/* File: include/drsu_pkg.sv */
package drsu_pkg;
  typedef enum logic [2:0] {
    DS_CMD    = 3'b000,
    DS_ADDR1  = 3'b001,
    DS_ADDR2  = 3'b010,
    DS_DUMMY  = 3'b011,
    DS_DATA   = 3'b100,
    DS_STAT   = 3'b101,
    DS_WDATA  = 3'b110,
    DS_IGNORE = 3'b111
  } drsu_dev_st_e;

  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_SHIFT = 2'b01,
    HS_GAP   = 2'b10
  } drsu_host_st_e;
endpackage : drsu_pkg

/* File: include/drsu_if.sv */
`timescale 1ns/10ps
interface drsu_if;
  logic cs_n;
  logic sck;
  logic protect_pin_n;
  logic h_lo;
  logic h_lo_oe;
  logic h_hi;
  logic h_hi_oe;
  logic d_lo;
  logic d_lo_oe;
  logic d_hi;
  logic d_hi_oe;
  logic low_data_lane;
  logic high_data_lane;

  // undriven lane reads high, as with a pull-up
  assign low_data_lane  = h_lo_oe ? h_lo : (d_lo_oe ? d_lo : 1'b1);
  assign high_data_lane = h_hi_oe ? h_hi : (d_hi_oe ? d_hi : 1'b1);

  modport dev (
    input  cs_n, sck, protect_pin_n, low_data_lane, high_data_lane,
    output d_lo, d_lo_oe, d_hi, d_hi_oe
  );
  modport host (
    input  low_data_lane, high_data_lane,
    output cs_n, sck, protect_pin_n, h_lo, h_lo_oe, h_hi, h_hi_oe
  );
endinterface : drsu_if

/* File: hw/drsu_host.sv */
`timescale 1ns/10ps
`include "drsu_map.svh"
module drsu_host #(
  parameter int HALF       = 4,
  parameter int GAP_CYCLES = 8
) (
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  drsu_if.host             lnk,
  input  wire logic        req_valid_in,
  input  wire logic [7:0]  req_op_in,
  input  wire logic [23:0] req_addr_in,
  input  wire logic [7:0]  req_wdata_in,
  input  wire logic [7:0]  req_len_in,
  input  wire logic        wp_level_in,
  output logic             req_ready_out,
  output logic [7:0]       rd_data_out,
  output logic             rd_valid_out,
  output logic             done_out
);
  drsu_pkg::drsu_host_st_e st_q;
  logic [7:0]  div_q;
  logic [7:0]  gap_q;
  logic        sck_q;
  logic        cs_n_q;
  logic        wp_q;
  logic [11:0] tk_q;
  logic [11:0] total_q;
  logic [11:0] dstart_q;
  logic [7:0]  op_q;
  logic [23:0] addr_q;
  logic [7:0]  wd_q;
  logic [3:0]  drv_q;
  logic        lo_s1_q, lo_s2_q, hi_s1_q, hi_s2_q;
  logic [7:0]  rx_q;
  logic [2:0]  rxc_q;
  logic        dual;
  logic        edge_now;
  logic [7:0]  rx_d;

  // returns {hi_oe, hi, lo_oe, lo} for tick t
  function automatic logic [3:0] drsu_drive(input logic [7:0] op,
    input logic [23:0] a, input logic [7:0] wd, input logic [11:0] t);
    logic [3:0]  r;
    logic [11:0] j;
    r = 4'h0;
    j = `DRSU_H_DIO_IDX - {t[10:0], 1'b0};
    if (t <= `DRSU_H_CMD_LAST)
      r = {3'b001, op[~t[2:0]]};
    else if (op == `DRSU_OP_DREAD && t <= `DRSU_H_DR_ADDR_END)
      r = {3'b001, a[5'(~t[4:0])]};
    else if (op == `DRSU_OP_DREAD && t <= `DRSU_H_DR_DUM_END)
      r = 4'b0010;
    else if (op == `DRSU_OP_DIOREAD && t <= `DRSU_H_DIO_ADR_END)
      r = {1'b1, a[5'(j)], 1'b1, a[5'(j - 12'h001)]};
    else if (op == `DRSU_OP_DIOREAD && t <= `DRSU_H_DIO_DRV_END)
      r = 4'b1010;
    else if (op == `DRSU_OP_WRSR && t <= `DRSU_H_WRSR_END)
      r = {3'b001, wd[~t[2:0]]};
    // lanes released from here on
    return r;
  endfunction : drsu_drive

  assign dual = op_q == `DRSU_OP_DREAD || op_q == `DRSU_OP_DIOREAD;
  assign edge_now = st_q == drsu_pkg::HS_SHIFT && div_q == 8'(HALF - 1);
  assign rx_d = dual ? {rx_q[5:0], lo_s2_q, hi_s2_q} : {rx_q[6:0], hi_s2_q};

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st_q <= drsu_pkg::HS_IDLE;
      div_q <= 8'h00;
      gap_q <= 8'h00;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      tk_q <= 12'h000;
      total_q <= 12'h000;
      dstart_q <= 12'h000;
      op_q <= 8'h00;
      addr_q <= 24'h000000;
      wd_q <= 8'h00;
      drv_q <= 4'h0;
      req_ready_out <= 1'b0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      unique case (st_q)
        drsu_pkg::HS_IDLE:
        begin
          req_ready_out <= 1'b1;
          if (req_valid_in && req_ready_out)
          begin
            req_ready_out <= 1'b0;
            st_q <= drsu_pkg::HS_SHIFT;
            cs_n_q <= 1'b0;
            tk_q <= 12'h000;
            div_q <= 8'h00;
            op_q <= req_op_in;
            addr_q <= req_addr_in;
            wd_q <= req_wdata_in;
            drv_q <= drsu_drive(req_op_in, req_addr_in, req_wdata_in, 12'h000);
            unique case (req_op_in)
              `DRSU_OP_DREAD:
              begin
                dstart_q <= `DRSU_H_DR_DSTART;
                total_q <= `DRSU_H_DR_DSTART + {2'b00, req_len_in, 2'b00};
              end
              `DRSU_OP_DIOREAD:
              begin
                dstart_q <= `DRSU_H_DIO_DSTART;
                total_q <= `DRSU_H_DIO_DSTART + {2'b00, req_len_in, 2'b00};
              end
              `DRSU_OP_RDSR:
              begin
                dstart_q <= `DRSU_H_SR_DSTART;
                total_q <= `DRSU_H_SR_DSTART + {1'b0, req_len_in, 3'b000};
              end
              `DRSU_OP_WRSR:
              begin
                dstart_q <= `DRSU_H_WRSR_TOTAL;
                total_q <= `DRSU_H_WRSR_TOTAL;
              end
              default:
              begin
                dstart_q <= `DRSU_H_ONE_TOTAL;
                total_q <= `DRSU_H_ONE_TOTAL;
              end
            endcase
          end
        end
        drsu_pkg::HS_SHIFT:
        begin
          div_q <= edge_now ? 8'h00 : div_q + 8'h01;
          if (edge_now)
          begin
            sck_q <= ~sck_q;
            if (sck_q && tk_q == total_q - 12'h001)
            begin
              st_q <= drsu_pkg::HS_GAP;
              cs_n_q <= 1'b1;
              drv_q <= 4'h0;
              gap_q <= 8'h00;
            end
            else if (sck_q)
            begin
              tk_q <= tk_q + 12'h001;
              drv_q <= drsu_drive(op_q, addr_q, wd_q, tk_q + 12'h001);
            end
          end
        end
        drsu_pkg::HS_GAP:
        begin
          gap_q <= gap_q + 8'h01;
          if (gap_q == 8'(GAP_CYCLES - 1))
          begin
            st_q <= drsu_pkg::HS_IDLE;
            done_out <= 1'b1;
          end
        end
        default:
          st_q <= drsu_pkg::HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      lo_s1_q <= 1'b1;
      lo_s2_q <= 1'b1;
      hi_s1_q <= 1'b1;
      hi_s2_q <= 1'b1;
      wp_q <= 1'b0;
    end
    else
    begin
      lo_s1_q <= lnk.low_data_lane;
      lo_s2_q <= lo_s1_q;
      hi_s1_q <= lnk.high_data_lane;
      hi_s2_q <= hi_s1_q;
      wp_q <= wp_level_in;
    end
  end

  // lanes sampled HALF cycles after the device's falling-edge update
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rx_q <= 8'h00;
      rxc_q <= 3'h0;
      rd_data_out <= 8'h00;
      rd_valid_out <= 1'b0;
    end
    else
    begin
      rd_valid_out <= 1'b0;
      if (st_q == drsu_pkg::HS_IDLE)
        rxc_q <= 3'h0;
      else if (edge_now && !sck_q && tk_q >= dstart_q)
      begin
        rx_q <= rx_d;
        rxc_q <= rxc_q + 3'h1;
        if (dual ? rxc_q[1:0] == 2'h3 : rxc_q == 3'h7)
        begin
          rd_data_out <= rx_d;
          rd_valid_out <= 1'b1;
        end
      end
    end
  end

  assign lnk.cs_n = cs_n_q;
  assign lnk.sck = sck_q;
  assign lnk.protect_pin_n = wp_q;
  assign lnk.h_hi_oe = drv_q[3];
  assign lnk.h_hi = drv_q[2];
  assign lnk.h_lo_oe = drv_q[1];
  assign lnk.h_lo = drv_q[0];
endmodule : drsu_host

/* File: hw/drsu_device.sv */
`timescale 1ns/10ps
`include "drsu_map.svh"
module drsu_device #(
  parameter int         ADDR_W      = 19,
  parameter int         WRSR_CYCLES = 16,
  parameter logic [7:0] NV_INIT     = 8'h00
) (
  input  wire logic              clock_in,
  input  wire logic              sys_rst_in,
  drsu_if.dev                    lnk,
  output logic [ADDR_W-1:0]      mem_addr_out,
  input  wire logic [7:0]        mem_data_in,
  input  wire logic              ext_busy_in,
  input  wire logic              ext_done_in,
  output logic [7:0]             status_out
);
  drsu_pkg::drsu_dev_st_e st_q;
  logic              frame_rst;
  logic [5:0]        cnt_q;
  logic [2:0]        pos_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0]        cmd_sr_q;
  logic [7:0]        cmd_q;
  logic [7:0]        data_q;
  logic              cmd_ready_q;
  logic              cmd_tgl_q;
  logic [7:0]        cmd_full;
  logic [7:0]        sts_s1_q, sts_s2_q;
  logic              lo_q, lo_oe_q, hi_q, hi_oe_q;
  logic              cs_s1_q, cs_s2_q, cs_s3_q;
  logic              rdy_s1_q, rdy_s2_q;
  logic              tgl_s1_q, tgl_s2_q, tgl_seen_q;
  logic              wp_s1_q, wp_s2_q;
  logic              wen_q;
  logic              wbusy_q;
  logic [7:0]        wtmr_q;
  logic [7:0]        nv_q;
  logic [7:0]        pend_q;
  logic              commit;
  logic              wrsr_go;
  logic              wrsr_done;
  logic              busy_any;

  // chip select doubles as frame reset of the link-side state, address and lane-drive logic
  assign frame_rst = sys_rst_in | lnk.cs_n;
  assign cmd_full = {cmd_sr_q[6:0], lnk.low_data_lane};

  always_ff @(posedge lnk.sck or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      st_q <= drsu_pkg::DS_CMD;
      cnt_q <= 6'h00;
      pos_q <= 3'h0;
    end
    else
    begin
      if (cnt_q != `DRSU_D_CNT_MAX)
        cnt_q <= cnt_q + 6'h01;
      unique case (st_q)
        drsu_pkg::DS_CMD:
          if (cnt_q == `DRSU_D_CMD_END)
          begin
            pos_q <= 3'h0;
            case (cmd_full)
              `DRSU_OP_DREAD:   st_q <= drsu_pkg::DS_ADDR1;
              `DRSU_OP_DIOREAD: st_q <= drsu_pkg::DS_ADDR2;
              `DRSU_OP_RDSR:    st_q <= drsu_pkg::DS_STAT;
              `DRSU_OP_WRSR:    st_q <= drsu_pkg::DS_WDATA;
              default:          st_q <= drsu_pkg::DS_IGNORE;
            endcase
          end
        drsu_pkg::DS_ADDR1:
          if (cnt_q == `DRSU_D_DR_ADDR_END)
            st_q <= drsu_pkg::DS_DUMMY;
        drsu_pkg::DS_ADDR2:
          if (cnt_q == `DRSU_D_DIO_ADR_END)
            st_q <= drsu_pkg::DS_DUMMY;
        drsu_pkg::DS_DUMMY:
          if ((cmd_q == `DRSU_OP_DIOREAD && cnt_q == `DRSU_D_DIO_DUM_END) ||
              (cmd_q == `DRSU_OP_DREAD && cnt_q == `DRSU_D_DR_DUM_END))
            st_q <= drsu_pkg::DS_DATA;
        drsu_pkg::DS_DATA:
          pos_q <= pos_q + 3'h1;
        drsu_pkg::DS_STAT:
          pos_q <= pos_q + 3'h1;
        drsu_pkg::DS_WDATA:
          if (cnt_q == `DRSU_D_WRSR_END)
            st_q <= drsu_pkg::DS_IGNORE;
        drsu_pkg::DS_IGNORE:
          st_q <= drsu_pkg::DS_IGNORE;
      endcase
    end
  end

  always_ff @(posedge lnk.sck or posedge frame_rst)
  begin
    if (frame_rst)
      addr_q <= '0;
    else if (st_q == drsu_pkg::DS_ADDR1)
      addr_q <= {addr_q[ADDR_W-2:0], lnk.low_data_lane};
    else if (st_q == drsu_pkg::DS_ADDR2)
      addr_q <= {addr_q[ADDR_W-3:0], lnk.high_data_lane,
                 lnk.low_data_lane};
    else if (st_q == drsu_pkg::DS_DATA && pos_q[1:0] == `DRSU_D_PAIR_LAST)
      addr_q <= addr_q + 1'b1;
  end

  // survives the chip select rise so the system side can commit it
  always_ff @(posedge lnk.sck or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cmd_sr_q <= 8'h00;
      cmd_q <= 8'h00;
      data_q <= 8'h00;
      cmd_ready_q <= 1'b0;
      cmd_tgl_q <= 1'b0;
      sts_s1_q <= 8'h00;
      sts_s2_q <= 8'h00;
    end
    else
    begin
      if (st_q == drsu_pkg::DS_CMD)
        cmd_sr_q <= cmd_full;
      if (st_q == drsu_pkg::DS_CMD && cnt_q == `DRSU_D_CMD_END)
        cmd_q <= cmd_full;
      if (st_q == drsu_pkg::DS_WDATA)
        data_q <= {data_q[6:0], lnk.low_data_lane};
      // any extra clock edge withdraws the request
      cmd_ready_q <= (st_q == drsu_pkg::DS_CMD &&
                      cnt_q == `DRSU_D_CMD_END &&
                      (cmd_full == `DRSU_OP_WREN ||
                       cmd_full == `DRSU_OP_WRDI)) ||
                     (st_q == drsu_pkg::DS_WDATA &&
                      cnt_q == `DRSU_D_WRSR_END);
      if (cnt_q == 6'h00)
        cmd_tgl_q <= ~cmd_tgl_q;
      sts_s1_q <= status_out;
      sts_s2_q <= sts_s1_q;
    end
  end

  // output lanes change on falling edges and are released when chip select rises
  always_ff @(negedge lnk.sck or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      lo_q <= 1'b0;
      lo_oe_q <= 1'b0;
      hi_q <= 1'b0;
      hi_oe_q <= 1'b0;
    end
    else if (st_q == drsu_pkg::DS_DATA)
    begin
      lo_oe_q <= 1'b1;
      hi_oe_q <= 1'b1;
      lo_q <= mem_data_in[{~pos_q[1:0], 1'b1}];
      hi_q <= mem_data_in[{~pos_q[1:0], 1'b0}];
    end
    else if (st_q == drsu_pkg::DS_STAT)
    begin
      lo_oe_q <= 1'b0;
      hi_oe_q <= 1'b1;
      hi_q <= sts_s2_q[~pos_q];
    end
    else
    begin
      lo_oe_q <= 1'b0;
      hi_oe_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      rdy_s1_q <= 1'b0;
      rdy_s2_q <= 1'b0;
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_seen_q <= 1'b0;
      wp_s1_q <= 1'b0;
      wp_s2_q <= 1'b0;
    end
    else
    begin
      cs_s1_q <= lnk.cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      rdy_s1_q <= cmd_ready_q;
      rdy_s2_q <= rdy_s1_q;
      tgl_s1_q <= cmd_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      wp_s1_q <= lnk.protect_pin_n;
      wp_s2_q <= wp_s1_q;
      if (cs_s2_q && !cs_s3_q)
        tgl_seen_q <= tgl_s2_q;
    end
  end

  // toggle guards against replaying the last frame's command
  assign commit = cs_s2_q && !cs_s3_q && rdy_s2_q &&
                  tgl_s2_q != tgl_seen_q;
  assign busy_any = wbusy_q | ext_busy_in;
  assign wrsr_go = commit && cmd_q == `DRSU_OP_WRSR && wen_q &&
                   !busy_any &&
                   !(nv_q[`DRSU_SR_LOCK] && !wp_s2_q);
  assign wrsr_done = wbusy_q && wtmr_q == 8'h00;

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      wen_q <= 1'b0;
    else if (commit && cmd_q == `DRSU_OP_WREN)
      wen_q <= 1'b1;
    else if (commit && cmd_q == `DRSU_OP_WRDI)
      wen_q <= 1'b0;
    else if (wrsr_done || ext_done_in)
      wen_q <= 1'b0;
  end

  // internal erase and program of the kept bits is one timed step
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      wbusy_q <= 1'b0;
      wtmr_q <= 8'h00;
      pend_q <= 8'h00;
      nv_q <= NV_INIT & `DRSU_SR_NV_MASK;
    end
    else if (wrsr_go)
    begin
      wbusy_q <= 1'b1;
      wtmr_q <= 8'(WRSR_CYCLES - 1);
      pend_q <= data_q & `DRSU_SR_NV_MASK;
    end
    else if (wrsr_done)
    begin
      wbusy_q <= 1'b0;
      nv_q <= pend_q;
    end
    else if (wbusy_q)
      wtmr_q <= wtmr_q - 8'h01;
  end

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      status_out <= 8'h00;
    else
      status_out <= nv_q | {6'h00, wen_q, busy_any};
  end

  assign mem_addr_out = addr_q;
  assign lnk.d_lo = lo_q;
  assign lnk.d_lo_oe = lo_oe_q;
  assign lnk.d_hi = hi_q;
  assign lnk.d_hi_oe = hi_oe_q;
endmodule : drsu_device

/* File: dv/drsu_link_sva.sv */
`timescale 1ns/10ps
module drsu_link_sva (
  input logic clock_in,
  input logic sys_rst_in,
  input logic cs_n,
  input logic sck,
  input logic low_data_lane,
  input logic h_lo_oe,
  input logic h_hi_oe,
  input logic d_lo,
  input logic d_lo_oe,
  input logic d_hi,
  input logic d_hi_oe
);
  logic       sck_q;
  logic [7:0] rises_q;
  logic [7:0] op_q;
  logic       off;

  assign off = !d_lo_oe && !d_hi_oe;

  always_ff @(posedge clock_in or posedge sys_rst_in)
    if (sys_rst_in) sck_q <= 1'b0;
    else sck_q <= sck;

  // saturates so a long stream cannot wrap back into the command window
  always_ff @(posedge clock_in or posedge sys_rst_in)
    if (sys_rst_in || cs_n) rises_q <= 8'h00;
    else if (sck && !sck_q && rises_q != 8'hff) rises_q <= rises_q + 8'h01;

  always_ff @(posedge clock_in or posedge sys_rst_in)
    if (sys_rst_in || cs_n) op_q <= 8'h00;
    else if (sck && !sck_q && rises_q < 8'h08)
      op_q <= {op_q[6:0], low_data_lane};

  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  a_desel_quiet: assert property (cs_n |-> off)
    else $error("lanes driven while deselected");
  a_lo_no_fight: assert property (!(h_lo_oe && d_lo_oe))
    else $error("both ends drive low lane");
  a_hi_no_fight: assert property (!(h_hi_oe && d_hi_oe))
    else $error("both ends drive high lane");
  a_cmd_silent: assert property (rises_q < 8'h08 |-> off)
    else $error("device drives during opcode");
  a_dread_wait: assert property (
    op_q == 8'h3b && rises_q < 8'd40 |-> off)
    else $error("dual read output too early");
  a_dio_wait: assert property (
    op_q == 8'hbb && rises_q < 8'd24 |-> off)
    else $error("dual io output too early");
  a_stat_one_lane: assert property (op_q == 8'h05 |-> !d_lo_oe)
    else $error("status read drives low lane");
  a_stat_start: assert property (
    op_q == 8'h05 && rises_q == 8'd8 && $fell(sck)
    |-> ##[0:1] d_hi_oe)
    else $error("status output late");
  a_dread_start: assert property (
    op_q == 8'h3b && rises_q == 8'd40 && $fell(sck)
    |-> ##[0:1] (d_lo_oe && d_hi_oe))
    else $error("dual read output late");
  a_dio_start: assert property (
    op_q == 8'hbb && rises_q == 8'd24 && $fell(sck)
    |-> ##[0:1] (d_lo_oe && d_hi_oe))
    else $error("dual io output late");
  a_out_steady: assert property (
    sck && $past(sck) && d_lo_oe && $past(d_lo_oe)
    |-> $stable(d_lo) && $stable(d_hi))
    else $error("output changed while clock high");
endmodule : drsu_link_sva

/* File: dv/dual_read_status_register_unit_tb.sv */
`timescale 1ns/10ps
module dual_read_status_register_unit_tb;
  logic        clock_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        req_valid = 1'b0;
  logic [7:0]  req_op = 8'h00;
  logic [23:0] req_addr = 24'h000000;
  logic [7:0]  req_wdata = 8'h00;
  logic [7:0]  req_len = 8'h00;
  logic        wp_level = 1'b1;
  logic        ext_busy = 1'b0;
  logic        ext_done = 1'b0;
  logic        req_ready_out, rd_valid_out, done_out;
  logic [7:0]  rd_data_out, status_out, mem_data;
  logic [18:0] mem_addr;
  logic [7:0]  exp_q[$];
  logic [7:0]  exp_b;
  integer      seed = 32'hc969;
  int          errors = 0;
  int          n_tests = 0;
  int          cycles = 0;

  drsu_if lnk_if();

  always #50 clock_in = ~clock_in;

  function automatic logic [7:0] mem_f(input logic [18:0] a);
    return a[7:0] + a[18:11];
  endfunction : mem_f

  assign mem_data = mem_f(mem_addr);

  drsu_host #(.HALF(4), .GAP_CYCLES(8)) drsu_host_inst (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .lnk(lnk_if),
    .req_valid_in(req_valid), .req_op_in(req_op), .req_addr_in(req_addr),
    .req_wdata_in(req_wdata), .req_len_in(req_len), .wp_level_in(wp_level),
    .req_ready_out(req_ready_out), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .done_out(done_out));

  // long status write time so a read can land inside it
  drsu_device #(.ADDR_W(19), .WRSR_CYCLES(200), .NV_INIT(8'h00))
  drsu_device_inst (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .lnk(lnk_if),
    .mem_addr_out(mem_addr), .mem_data_in(mem_data),
    .ext_busy_in(ext_busy), .ext_done_in(ext_done),
    .status_out(status_out));

  drsu_link_sva drsu_link_sva_inst (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .cs_n(lnk_if.cs_n),
    .sck(lnk_if.sck), .low_data_lane(lnk_if.low_data_lane),
    .h_lo_oe(lnk_if.h_lo_oe), .h_hi_oe(lnk_if.h_hi_oe),
    .d_lo(lnk_if.d_lo), .d_lo_oe(lnk_if.d_lo_oe),
    .d_hi(lnk_if.d_hi), .d_hi_oe(lnk_if.d_hi_oe));

  task automatic test_done;
    $display("checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles > 60000)
    begin
      errors++;
      test_done();
    end
  end

  always @(posedge clock_in)
    if (rd_valid_out === 1'b1)
    begin
      exp_b = exp_q.size() ? exp_q.pop_front() : 8'hxx;
      check(rd_data_out, exp_b);
    end

  task automatic req(input logic [7:0] op, input logic [23:0] a,
                     input logic [7:0] wd, input logic [7:0] len);
    int n;
    n = 0;
    @(posedge clock_in);
    while (req_ready_out !== 1'b1 && n < 20000)
    begin
      @(posedge clock_in);
      n++;
    end
    if (n >= 20000)
      errors++;
    req_op <= op;
    req_addr <= a;
    req_wdata <= wd;
    req_len <= len;
    req_valid <= 1'b1;
    @(posedge clock_in);
    req_valid <= 1'b0;
    n = 0;
    while (done_out !== 1'b1 && n < 20000)
    begin
      @(posedge clock_in);
      n++;
    end
    if (n >= 20000)
      errors++;
  endtask : req

  // status read of two passes shows the repeat from the top bit
  task automatic rd_st(input logic [7:0] exp);
    exp_q.push_back(exp);
    exp_q.push_back(exp);
    // looked at before the frame: a running write may finish during it
    check(status_out, exp);
    req(8'h05, 24'h000000, 8'h00, 8'd2);
  endtask : rd_st

  task automatic rd_dual(input logic [7:0] op, input logic [23:0] a,
                         input logic [7:0] len);
    for (int i = 0; i < len; i++)
      exp_q.push_back(mem_f(a[18:0] + 19'(i)));
    req(op, a, 8'h00, len);
  endtask : rd_dual

  initial
  begin
    repeat (8) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    rd_st(8'h00);
    req(8'h06, 24'h000000, 8'h00, 8'd0);
    for (int k = 0; k < 6; k++)
      rd_dual(k[0] ? 8'hbb : 8'h3b, 24'($random(seed)),
              8'd1 + 8'($unsigned($random(seed)) % 3));
    rd_dual(8'h3b, 24'h07fffe, 8'd3);
    rd_dual(8'hbb, 24'hf7fffe, 8'd3);
    rd_st(8'h02);
    req(8'h01, 24'h000000, 8'hff, 8'd0);
    rd_st(8'h03);
    repeat (250) @(posedge clock_in);
    rd_st(8'hbc);
    wp_level <= 1'b0;
    req(8'h06, 24'h000000, 8'h00, 8'd0);
    req(8'h01, 24'h000000, 8'h00, 8'd0);
    repeat (250) @(posedge clock_in);
    rd_st(8'hbe);
    wp_level <= 1'b1;
    req(8'h01, 24'h000000, 8'h00, 8'd0);
    repeat (250) @(posedge clock_in);
    rd_st(8'h00);
    req(8'h06, 24'h000000, 8'h00, 8'd0);
    req(8'h04, 24'h000000, 8'h00, 8'd0);
    req(8'h01, 24'h000000, 8'hff, 8'd0);
    repeat (250) @(posedge clock_in);
    rd_st(8'h00);
    ext_busy <= 1'b1;
    req(8'h06, 24'h000000, 8'h00, 8'd0);
    rd_st(8'h03);
    ext_busy <= 1'b0;
    ext_done <= 1'b1;
    @(posedge clock_in);
    ext_done <= 1'b0;
    repeat (5) @(posedge clock_in);
    rd_st(8'h00);
    check(8'(exp_q.size()), 8'h00);
    test_done();
  end
endmodule : dual_read_status_register_unit_tb
